// File: rtl/rftx_ctrl.sv
// Purpose: operating-mode sequencer and synthesizer settings of an RF transmitter
// Assumes: clk is the reference clock; serial pins come from the host asynchronously
// Notes: serial frame is 2 command bits, 6 address bits, then data bytes, MSB first
// Summary of operation
// - Long enable low forces sleep and reset
// - Sleep bit makes enable fall sleep immediately
// - Sleep entry clears mode control and checksum only
// - Enable rise leaves sleep, clock/16 out
// - Clock output within 100 us
// - Power-up in clock-buffer mode, long clock
// - Standby bit moves clock-buffer to standby
// - Transmit command only from standby
// - Serial clock rise after settle starts amplifier
// - Enable fall stops amplifier after 100 ns
// - Writes ignored while transmitting
// - Divide select picks carrier ratio 2 or 1
// - Feedback ratio integer plus scaled fraction
// - Integer code offset by sixteen
// - Per-channel divider registers at 0x00-0x09
// - Deviation scaled by x4 and x2 bits
// - Carrier shifts up/down with data bit
// - Ramp time from divider, deviation, ramp
// - Command 11b is transmit command
// - Channel bits select one of four
`timescale 1ns/1ns
`include "rftx_params.svh"
module rftx_ctrl
  import rftx_pkg::*;
#(
  parameter int LOW_CYCLES = `RFTX_LOW_TIME_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic enable_in,
  input wire logic serial_clk_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe_n,
  output logic divided_clock_out,
  output logic rf_power_output,
  output logic fsk_shift_up,
  output logic [1:0] mode_out,
  output logic [1:0] active_channel,
  output logic [4:0] feedback_integer_ratio,
  output logic [15:0] feedback_fraction_code,
  output logic [17:0] fraction_numerator,
  output logic [1:0] carrier_divide_ratio,
  output logic [25:0] deviation_scaled,
  output logic [31:0] ramp_periods
);
  localparam int PA_OFF_CYC = (`RFTX_PA_OFF_NS + `RFTX_CLK_NS - 1) / `RFTX_CLK_NS;

  // Byte address of a channel field; channels come in pairs five bytes apart,
  // so all four channels fit below the output divider select byte
  function automatic logic [5:0] ch_addr(input logic [5:0] base, input logic [1:0] ch);
    ch_addr = base + (ch[1] ? `RFTX_CH_PAIR_STEP : 6'h00) + (ch[0] ? `RFTX_CH_FRAC_STEP : 6'h00);
  endfunction

  // Pin synchronisers, first stage read by second only
  logic [1:0] en_s, sck_s, sdi_s;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_s <= 2'h0;
      sck_s <= 2'h0;
      sdi_s <= 2'h0;
    end else begin
      en_s <= {en_s[0], enable_in};
      sck_s <= {sck_s[0], serial_clk_in};
      sdi_s <= {sdi_s[0], serial_data_in};
    end
  end
  logic en_d_r, sck_d_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_d_r <= 1'b0;
      sck_d_r <= 1'b0;
    end else begin
      en_d_r <= en_s[1];
      sck_d_r <= sck_s[1];
    end
  end
  logic en_rise, en_fall, sck_rise, sck_fall;
  assign en_rise = en_s[1] & ~en_d_r;
  assign en_fall = ~en_s[1] & en_d_r;
  assign sck_rise = sck_s[1] & ~sck_d_r;
  assign sck_fall = ~sck_s[1] & sck_d_r;

  rftx_mode_t mode_r;
  logic [7:0] regs_r [`RFTX_REG_COUNT];
  logic sleep_bit, standby_bit;
  assign sleep_bit = regs_r[`RFTX_ADDR_MODE_CTRL][`RFTX_BIT_SLEEP];
  assign standby_bit = regs_r[`RFTX_ADDR_MODE_CTRL][`RFTX_BIT_STANDBY];

  // Enable-low counter; a single high sample restarts it
  logic [18:0] low_cnt_r;
  logic low_expired;
  assign low_expired = (low_cnt_r == 19'(LOW_CYCLES - 1)) & ~en_s[1];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt_r <= 19'h00000;
    end else if (en_s[1]) begin
      low_cnt_r <= 19'h00000;
    end else if (low_cnt_r != 19'(LOW_CYCLES - 1)) begin
      low_cnt_r <= low_cnt_r + 19'h00001;
    end
  end
  logic go_sleep;
  assign go_sleep = mode_r != RFTX_SLEEP && (low_expired || (en_fall && sleep_bit));

  // Serial receiver: counts bits inside one enable-high frame
  logic [7:0] sh_r;
  logic [3:0] bit_cnt_r;
  logic hdr_done_r;
  logic [1:0] cmd_r;
  logic [5:0] addr_r;
  logic [7:0] chk_r;
  logic byte_done;
  assign byte_done = sck_rise && en_s[1] && bit_cnt_r == 4'h7;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sh_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      hdr_done_r <= 1'b0;
      cmd_r <= 2'h0;
      addr_r <= 6'h00;
    end else if (!en_s[1]) begin
      bit_cnt_r <= 4'h0;
      hdr_done_r <= 1'b0;
    end else if (sck_rise) begin
      sh_r <= {sh_r[6:0], sdi_s[1]};
      bit_cnt_r <= (bit_cnt_r == 4'h7) ? 4'h0 : bit_cnt_r + 4'h1;
      if (byte_done) begin
        if (!hdr_done_r) begin
          hdr_done_r <= 1'b1;
          cmd_r <= sh_r[6:5];
          addr_r <= {sh_r[4:0], sdi_s[1]};
        end else begin
          addr_r <= addr_r + 6'h01; // Burst auto-increment
        end
      end
    end
  end
  logic hdr_now, tx_cmd, wr_now;
  assign hdr_now = byte_done && !hdr_done_r;
  assign tx_cmd = hdr_now && sh_r[6:5] == `RFTX_CMD_TX;
  assign wr_now = byte_done && hdr_done_r && cmd_r == `RFTX_CMD_WRITE && mode_r != RFTX_TX;

  // Register file; only mode control is a control register cleared on sleep
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `RFTX_REG_COUNT; i++) begin
        regs_r[i] <= 8'h00;
      end
    end else if (go_sleep) begin
      regs_r[`RFTX_ADDR_MODE_CTRL] <= `RFTX_MODE_CTRL_RST;
    end else if (wr_now && addr_r != `RFTX_ADDR_CHK) begin
      regs_r[addr_r] <= {sh_r[6:0], sdi_s[1]};
    end
  end
  // Write checksum, cleared on sleep or a write to itself
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chk_r <= 8'h00;
    end else if (go_sleep || (wr_now && addr_r == `RFTX_ADDR_CHK)) begin
      chk_r <= 8'h00;
    end else if (byte_done && (wr_now || (hdr_now && sh_r[6:5] == `RFTX_CMD_WRITE))) begin
      chk_r <= chk_r ^ {sh_r[6:0], sdi_s[1]};
    end
  end

  // Read data shifts out on serial clock falls, driver on during read data phase
  logic [7:0] rd_sh_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_sh_r <= 8'h00;
    end else if (byte_done && (hdr_now ? sh_r[6:5] == `RFTX_CMD_READ : cmd_r == `RFTX_CMD_READ)) begin
      rd_sh_r <= (hdr_now ? {sh_r[4:0], sdi_s[1]} : addr_r + 6'h01) == `RFTX_ADDR_CHK ? chk_r :
                 regs_r[hdr_now ? {sh_r[4:0], sdi_s[1]} : addr_r + 6'h01];
    end else if (sck_fall && hdr_done_r && bit_cnt_r != 4'h0) begin
      rd_sh_r <= {rd_sh_r[6:0], 1'b0};
    end
  end
  assign serial_data_out = rd_sh_r[7];
  assign serial_data_oe_n = ~(en_s[1] && hdr_done_r && cmd_r == `RFTX_CMD_READ);

  // Transmit arming, amplifier on at first serial clock rise after the command
  logic armed_r, pa_r;
  logic [2:0] pa_off_cnt_r;
  logic [1:0] ch_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      armed_r <= 1'b0;
      ch_r <= 2'h0;
    end else if (tx_cmd && mode_r == RFTX_STANDBY) begin
      armed_r <= 1'b1;
      ch_r <= {sh_r[0], sdi_s[1]};
    end else if (go_sleep || !en_s[1] || (armed_r && sck_rise)) begin
      armed_r <= 1'b0;
    end
  end

  // Mode sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= RFTX_CLKBUF;
    end else if (go_sleep) begin
      mode_r <= RFTX_SLEEP;
    end else begin
      case (mode_r)
        RFTX_SLEEP: begin
          if (en_rise) begin
            mode_r <= RFTX_CLKBUF;
          end
        end
        RFTX_CLKBUF: begin
          if (standby_bit) begin
            mode_r <= RFTX_STANDBY;
          end
        end
        RFTX_STANDBY: begin
          if (armed_r && sck_rise) begin
            mode_r <= RFTX_TX;
          end
        end
        RFTX_TX: begin
          if (pa_off_cnt_r == 3'(PA_OFF_CYC)) begin
            mode_r <= RFTX_STANDBY;
          end
        end
        default: mode_r <= RFTX_SLEEP;
      endcase
    end
  end

  // Amplifier stops a fixed delay after enable falls
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pa_off_cnt_r <= 3'h0;
    end else if (mode_r != RFTX_TX) begin
      pa_off_cnt_r <= 3'h0;
    end else if (en_fall || pa_off_cnt_r != 3'h0) begin
      pa_off_cnt_r <= pa_off_cnt_r + 3'h1;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pa_r <= 1'b0;
    end else if (mode_r == RFTX_STANDBY && armed_r && sck_rise && !go_sleep) begin
      pa_r <= 1'b1;
    end else if (mode_r != RFTX_TX || pa_off_cnt_r == 3'(PA_OFF_CYC)) begin
      pa_r <= 1'b0;
    end
  end
  assign rf_power_output = pa_r;

  // Frequency shift follows data while transmitting
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fsk_shift_up <= 1'b0;
    end else begin
      fsk_shift_up <= pa_r & sdi_s[1];
    end
  end

  // Reference divided by sixteen, held at zero in sleep and restarted from zero on wake
  logic [3:0] div_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_r <= 4'h0;
    end else if (mode_r == RFTX_SLEEP) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end
  assign divided_clock_out = div_r[3];
  assign mode_out = mode_r;
  assign active_channel = ch_r;

  // Synthesizer settings for the selected channel, registered
  logic [15:0] frac_w;
  logic [3:0] int_w;
  logic [7:0] int_byte_w;
  logic dev_x4_w, dev_x2_w;
  logic carrier_divide_ratio_w;
  logic [7:0] deviation_setting_w;
  assign frac_w = {regs_r[ch_addr(`RFTX_ADDR_CH1_FRAC_HI, ch_r)],
                   regs_r[ch_addr(`RFTX_ADDR_CH1_FRAC_LO, ch_r)]};
  // Two channels share one integer byte, lower channel in the low nibble
  assign int_byte_w = regs_r[ch_addr(`RFTX_ADDR_CH1_INT, {ch_r[1], 1'b0})];
  assign int_w = ch_r[0] ? int_byte_w[7:4] : int_byte_w[3:0];
  assign carrier_divide_ratio_w = regs_r[`RFTX_ADDR_CARRIER_DIVIDE_RATIO_SEL][ch_r];
  assign deviation_setting_w = regs_r[`RFTX_ADDR_DEVIATION_SETTING];
  assign dev_x4_w = regs_r[`RFTX_ADDR_DEVIATION_SETTING_SCALE][`RFTX_BIT_DEV4X];
  assign dev_x2_w = regs_r[`RFTX_ADDR_DEVIATION_SETTING_SCALE][`RFTX_BIT_DEV2X];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      feedback_integer_ratio <= `RFTX_INT_OFFSET;
      feedback_fraction_code <= 16'h0000;
      fraction_numerator <= 18'h00003;
      carrier_divide_ratio <= 2'h1;
      deviation_scaled <= 26'h0000000;
      ramp_periods <= 32'h00000000;
    end else begin
      feedback_integer_ratio <= `RFTX_INT_OFFSET + {1'b0, int_w};
      feedback_fraction_code <= frac_w;
      fraction_numerator <= {frac_w, 2'h3};
      carrier_divide_ratio <= carrier_divide_ratio_w ? 2'h2 : 2'h1;
      deviation_scaled <= {18'h00000, deviation_setting_w} << (dev_x4_w ? 2'h2 : 2'h0) << (dev_x2_w ? 2'h1 : 2'h0);
      ramp_periods <= 32'({2'h0, carrier_divide_ratio_w ? 2'h2 : 2'h1} * 2 * deviation_setting_w * regs_r[`RFTX_ADDR_FREQ_RAMP_SETTING]);
    end
  end

  // Mode and amplifier consistency checks
  a_tx_needs_pa: assert property (@(posedge clk) disable iff (!nrst)
    $rose(mode_r == RFTX_TX) |-> pa_r) else $error("entered transmit without amplifier");
  a_pa_off_delay: assert property (@(posedge clk) disable iff (!nrst)
    (mode_r == RFTX_TX && en_fall && !go_sleep) |-> ##[1:4] !pa_r) else $error("amplifier late off");
  a_sleep_bit: assert property (@(posedge clk) disable iff (!nrst)
    (mode_r != RFTX_SLEEP && en_fall && sleep_bit) |=> mode_r == RFTX_SLEEP) else $error("no quick sleep");
  a_long_low: assert property (@(posedge clk) disable iff (!nrst)
    (low_expired && mode_r != RFTX_SLEEP) |=> mode_r == RFTX_SLEEP) else $error("no sleep on low");
  a_wake_clkbuf: assert property (@(posedge clk) disable iff (!nrst)
    (mode_r == RFTX_SLEEP && en_rise) |=> mode_r == RFTX_CLKBUF) else $error("no wake");
  a_ctrl_cleared: assert property (@(posedge clk) disable iff (!nrst)
    go_sleep |=> regs_r[`RFTX_ADDR_MODE_CTRL] == `RFTX_MODE_CTRL_RST) else $error("control kept");
  a_tx_only_standby: assert property (@(posedge clk) disable iff (!nrst)
    (tx_cmd && mode_r != RFTX_STANDBY) |=> !armed_r || $past(armed_r)) else $error("armed outside");
  a_no_tx_write: assert property (@(posedge clk) disable iff (!nrst)
    (mode_r == RFTX_TX && !go_sleep) |=> $stable(regs_r[`RFTX_ADDR_DEVIATION_SETTING])) else $error("write in tx");
  a_clk_runs: assert property (@(posedge clk) disable iff (!nrst)
    (mode_r == RFTX_CLKBUF) [*8] |-> $changed(divided_clock_out) || $past(divided_clock_out) != divided_clock_out
    || div_r != 4'h0) else $error("clock output stuck");
  a_int_offset: assert property (@(posedge clk) disable iff (!nrst)
    feedback_integer_ratio >= 5'h10) else $error("integer ratio below sixteen");
  a_low_clear: assert property (@(posedge clk) disable iff (!nrst)
    en_s[1] |=> low_cnt_r == 19'h00000) else $error("low counter not cleared");
  // Divider restarts from zero on wake, so the first output rise is half a period away
  a_divided_clock_out_start: assert property (@(posedge clk) disable iff (!nrst)
    $fell(mode_r == RFTX_SLEEP) |-> ##[1:16] divided_clock_out) else $error("clock output not started");
endmodule

// File: rtl/rftx_params.svh
// Purpose: constants for the transmitter mode and synthesizer control block
// Assumes: one 8-bit register file addressed by a 6-bit serial address
// Notes: offsets, field positions, reset values and timing counts
`ifndef RFTX_PARAMS_SVH
`define RFTX_PARAMS_SVH
`define RFTX_ADDR_CH1_FRAC_HI 6'h00
`define RFTX_ADDR_CH1_FRAC_LO 6'h01
`define RFTX_ADDR_CH1_INT 6'h04
`define RFTX_ADDR_CH_INT_LAST 6'h09
`define RFTX_CH_PAIR_STEP 6'h05
`define RFTX_CH_FRAC_STEP 6'h02
`define RFTX_ADDR_DEVIATION_SETTING_SCALE 6'h11
`define RFTX_ADDR_CARRIER_DIVIDE_RATIO_SEL 6'h0A
`define RFTX_ADDR_DEVIATION_SETTING 6'h0B
`define RFTX_ADDR_FREQ_RAMP_SETTING 6'h10
`define RFTX_ADDR_MODE_CTRL 6'h15
`define RFTX_ADDR_CHK 6'h16
`define RFTX_REG_COUNT 64
`define RFTX_BIT_SLEEP 0
`define RFTX_BIT_STANDBY 1
`define RFTX_BIT_DEV4X 0
`define RFTX_BIT_DEV2X 1
`define RFTX_MODE_CTRL_RST 8'h00
`define RFTX_CMD_READ 2'h0
`define RFTX_CMD_WRITE 2'h1
`define RFTX_CMD_TX 2'h3
`define RFTX_LOW_TIME_CYCLES 262144
`define RFTX_REF_DIV 16
`define RFTX_DIVIDED_CLOCK_OUT_MAX_NS 100000
`define RFTX_PA_OFF_NS 100
`define RFTX_CLK_NS 40
`define RFTX_INT_OFFSET 5'h10
`define RFTX_FRAC_SHIFT 18
`endif

// File: rtl/rftx_pkg.sv
// Purpose: types for the transmitter mode sequencer
// Assumes: nothing beyond the constants header
// Notes: mode codes are binary and written out
package rftx_pkg;
  typedef enum logic [1:0] {
    RFTX_SLEEP = 2'h0,
    RFTX_CLKBUF = 2'h1,
    RFTX_STANDBY = 2'h2,
    RFTX_TX = 2'h3
  } rftx_mode_t;
endpackage

// File: sim/rftx_host.sv
// Purpose: host model driving the enable, serial clock and serial data pins
// Assumes: four reference clocks per serial half period, MSB first
// Notes: serial clock stands low and data toggles between frames
`timescale 1ns/1ns
module rftx_host #(
  parameter int SETTLE = 8
) (
  input wire logic clk,
  input wire logic serial_data_out,
  output logic enable_in,
  output logic serial_clk_in,
  output logic serial_data_in
);
  // Idle pins at time zero
  initial begin
    enable_in = 1'b0;
    serial_clk_in = 1'b0;
    serial_data_in = 1'b0;
  end
  // Waits whole reference cycles
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data set with the clock low, held across the rising edge
  task automatic send_bit(input logic b);
    serial_clk_in <= 1'b0;
    serial_data_in <= b;
    wait_clk(4);
    serial_clk_in <= 1'b1;
    wait_clk(4);
  endtask
  // Header then optional data byte; enable stays high afterwards
  task automatic frame(input logic [7:0] hdr, input logic [7:0] dat, input logic has_dat);
    @(posedge clk);
    enable_in <= 1'b1;
    wait_clk(4);
    for (int i = 7; i >= 0; i--) send_bit(hdr[i]);
    if (has_dat) begin
      for (int i = 7; i >= 0; i--) send_bit(dat[i]);
    end
    serial_clk_in <= 1'b0;
    wait_clk(4);
  endtask
  // Waits for the synthesizer before the rise that starts the amplifier
  task automatic pa_rise();
    wait_clk(SETTLE);
    serial_clk_in <= 1'b1;
    wait_clk(6);
  endtask
  // Transmit data level while the amplifier runs
  task automatic tx_bit(input logic b);
    @(posedge clk);
    serial_data_in <= b;
    wait_clk(6);
  endtask
  // Ends a frame; data line no longer holds its last value
  task automatic release_frame();
    @(posedge clk);
    enable_in <= 1'b0;
    serial_clk_in <= 1'b0;
    serial_data_in <= ~serial_data_in;
    wait_clk(4);
  endtask
  // Register write, then release
  task automatic wr(input logic [5:0] addr, input logic [7:0] dat);
    frame({2'b01, addr}, dat, 1'b1);
    release_frame();
  endtask
  // Register read; each bit taken just before the serial clock rise, enable left high
  task automatic rd(input logic [5:0] addr, output logic [7:0] dat);
    frame({2'b00, addr}, 8'h00, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      serial_clk_in <= 1'b0;
      wait_clk(4);
      dat[i] = serial_data_out;
      serial_clk_in <= 1'b1;
      wait_clk(4);
    end
  endtask
endmodule

// File: sim/rftx_ctrl_bench.sv
// Purpose: self-checking bench for the mode sequencer and synthesizer settings
// Assumes: low-time count shortened to 64 cycles
// Notes: gaps with enable low stay under 64 cycles unless sleep is wanted
`timescale 1ns/1ns
module rftx_ctrl_bench;
  import rftx_pkg::*;
  logic clk, nrst, enable_in, serial_clk_in, serial_data_in;
  logic divided_clock_out, rf_power_output, fsk_shift_up, serial_data_oe_n, serial_data_out;
  logic [7:0] rdat;
  logic [1:0] mode_out, active_channel, carrier_divide_ratio;
  logic [4:0] feedback_integer_ratio;
  logic [15:0] feedback_fraction_code;
  logic [17:0] fraction_numerator;
  logic [25:0] deviation_scaled;
  logic [31:0] ramp_periods;
  int errors = 0;
  int check_count = 0;
  int r;
  rftx_ctrl #(.LOW_CYCLES(64)) DUT (.clk(clk), .nrst(nrst), .enable_in(enable_in),
    .serial_clk_in(serial_clk_in), .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n), .divided_clock_out(divided_clock_out),
    .rf_power_output(rf_power_output), .fsk_shift_up(fsk_shift_up), .mode_out(mode_out),
    .active_channel(active_channel), .feedback_integer_ratio(feedback_integer_ratio),
    .feedback_fraction_code(feedback_fraction_code), .fraction_numerator(fraction_numerator),
    .carrier_divide_ratio(carrier_divide_ratio), .deviation_scaled(deviation_scaled),
    .ramp_periods(ramp_periods));
  rftx_host host (.clk(clk), .serial_data_out(serial_data_out), .enable_in(enable_in),
    .serial_clk_in(serial_clk_in), .serial_data_in(serial_data_in));
  // 25 MHz reference, running in every mode
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Compares and counts
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Counts divided clock rises, sampled on falling edges
  task automatic count_rises(input int n, output int cnt);
    logic last;
    cnt = 0;
    @(negedge clk);
    last = divided_clock_out;
    repeat (n) begin
      @(negedge clk);
      if (divided_clock_out === 1'b1 && last === 1'b0) cnt++;
      last = divided_clock_out;
    end
  endtask
  task automatic results();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Power-up in clock-buffer mode, then long low time forces sleep
  task automatic t_power_up();
    repeat (3) @(negedge clk);
    check(mode_out, RFTX_CLKBUF);
    check(feedback_integer_ratio, 5'h10);
    check(fraction_numerator, 18'h00003);
    check(carrier_divide_ratio, 2'h1);
    check(serial_data_oe_n, 1'b1);
    count_rises(32, r);
    check(r, 32'h2);
    repeat (45) @(negedge clk);
    check(mode_out, RFTX_SLEEP);
    check(divided_clock_out, 1'b0);
  endtask
  // Enable rise wakes; configuration rewritten; transmit refused outside standby
  task automatic t_wake_config();
    host.wr(6'h0B, 8'h1F);
    @(negedge clk);
    check(mode_out, RFTX_CLKBUF);
    count_rises(32, r);
    check(r, 32'h2);
    host.wr(6'h11, 8'h03);
    host.wr(6'h10, 8'h05);
    host.wr(6'h0A, 8'hFF);
    host.wr(6'h00, 8'hAF);
    host.wr(6'h01, 8'hFF);
    host.wr(6'h04, 8'h03);
    host.wr(6'h09, 8'h50);
    host.rd(6'h04, rdat);
    @(negedge clk);
    check(rdat, 8'h03);
    check(serial_data_oe_n, 1'b0);
    host.release_frame();
    host.frame(8'hC0, 8'h00, 1'b0);
    host.pa_rise();
    @(negedge clk);
    check(mode_out, RFTX_CLKBUF);
    check(rf_power_output, 1'b0);
    host.release_frame();
    host.wr(6'h15, 8'h02);
    @(negedge clk);
    check(mode_out, RFTX_STANDBY);
  endtask
  // Transmit on channel one, FSK data, then enable fall
  task automatic t_transmit();
    host.frame(8'hC0, 8'h00, 1'b0);
    host.pa_rise();
    @(negedge clk);
    check(mode_out, RFTX_TX);
    check(rf_power_output, 1'b1);
    check(active_channel, 2'h0);
    check(feedback_integer_ratio, 5'h13);
    check(feedback_fraction_code, 16'hAFFF);
    check(fraction_numerator, 18'h2BFFF);
    check(carrier_divide_ratio, 2'h2);
    check(deviation_scaled, 26'h00000F8);
    check(ramp_periods, 32'h0000026C);
    host.tx_bit(1'b1);
    @(negedge clk);
    check(fsk_shift_up, 1'b1);
    host.tx_bit(1'b0);
    @(negedge clk);
    check(fsk_shift_up, 1'b0);
    host.release_frame();
    host.wait_clk(4);
    @(negedge clk);
    check(rf_power_output, 1'b0);
    check(mode_out, RFTX_STANDBY);
    host.frame(8'hC3, 8'h00, 1'b0);
    host.pa_rise();
    @(negedge clk);
    check(active_channel, 2'h3);
    check(feedback_integer_ratio, 5'h15);
    check(feedback_fraction_code, 16'h0000);
    host.release_frame();
  endtask
  // Interrupted low periods, then immediate sleep and control clear
  task automatic t_sleep();
    host.wait_clk(40);
    host.wr(6'h0B, 8'h1F);
    host.wait_clk(40);
    @(negedge clk);
    check(mode_out, RFTX_STANDBY);
    host.wr(6'h15, 8'h03);
    host.wait_clk(2);
    @(negedge clk);
    check(mode_out, RFTX_SLEEP);
    check(deviation_scaled, 26'h00000F8);
    host.frame(8'h4B, 8'h1F, 1'b1);
    @(negedge clk);
    check(mode_out, RFTX_CLKBUF);
    host.release_frame();
  endtask
  // Main sequence
  initial begin
    nrst = 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_power_up();
    t_wake_config();
    t_transmit();
    t_sleep();
    results();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end
endmodule
